// *** gple_consts.svh ***
`ifndef GPLE_CONSTS_SVH
`define GPLE_CONSTS_SVH

// register indices; byte address is four times the index
`define GPLE_IDX_LEVEL_LOW_CFG 8'h57
`define GPLE_IDX_LEVEL_HIGH_CFG 8'h58
`define GPLE_IDX_SPARE 8'h59
`define GPLE_IDX_CHECKSUM 8'h7E

// field positions
`define GPLE_TB_MSB 15
`define GPLE_TB_LSB 14
`define GPLE_HC_MSB 13
`define GPLE_HC_LSB 7
`define GPLE_LC_MSB 6
`define GPLE_LC_LSB 0

// reset values
`define GPLE_RST_LEVEL_LOW_CFG 16'h007F
`define GPLE_RST_LEVEL_HIGH_CFG 16'h3F80
`define GPLE_RST_SPARE 16'h5555
`define GPLE_RST_CHECKSUM 16'h0000

// time base lengths in master clocks
`define GPLE_TB_CLKS_0 11'h010
`define GPLE_TB_CLKS_1 11'h040
`define GPLE_TB_CLKS_2 11'h100
`define GPLE_TB_CLKS_3 11'h400

// bus responses
`define GPLE_RESP_OKAY 2'h0
`define GPLE_RESP_SLVERR 2'h2

`endif

// *** gple_encoder.sv ***
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "gple_consts.svh"

module gple_encoder (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pin side
  input wire logic pin_level,
  output logic fourth_io_overcurrent_pin
);

  // ==========================================================
  // helpers
  // ==========================================================
  function automatic logic idx_known(input logic [7:0] idx);
    idx_known = (idx == `GPLE_IDX_LEVEL_LOW_CFG) || (idx == `GPLE_IDX_LEVEL_HIGH_CFG) ||
                (idx == `GPLE_IDX_SPARE) || (idx == `GPLE_IDX_CHECKSUM);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] val,
                                        input logic [1:0] strb);
    merge = {strb[1] ? val[15:8] : old[15:8], strb[0] ? val[7:0] : old[7:0]};
  endfunction

  function automatic logic [10:0] tb_clks(input logic [1:0] sel);
    case (sel)
      2'h0: tb_clks = `GPLE_TB_CLKS_0;
      2'h1: tb_clks = `GPLE_TB_CLKS_1;
      2'h2: tb_clks = `GPLE_TB_CLKS_2;
      default: tb_clks = `GPLE_TB_CLKS_3;
    endcase
  endfunction

  gple_pkg::gple_state_t st_reg;
  gple_pkg::gple_state_t st_next;

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    logic [7:0] ar_idx;
    logic [15:0] rd_val;
    logic tick;
    logic boundary;
    logic [7:0] period;
    logic [6:0] hc;
    logic [6:0] lc;
    ar_idx = s_axi_araddr[9:2];
    rd_val = 16'h0000;
    tick = 1'b0;
    boundary = 1'b0;
    period = 8'h00;
    hc = 7'h00;
    lc = 7'h00;
    st_next = st_reg;

    // write address and data, taken in either order
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_held = 1'b1;
      st_next.aw_idx = s_axi_awaddr[9:2];
      st_next.awready = 1'b0;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata[15:0];
      st_next.w_strb = s_axi_wstrb[1:0];
      st_next.wready = 1'b0;
    end
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = idx_known(st_reg.aw_idx) ? `GPLE_RESP_OKAY : `GPLE_RESP_SLVERR;
      case (st_reg.aw_idx)
        `GPLE_IDX_LEVEL_LOW_CFG: begin
          st_next.level_low_cfg = merge(st_reg.level_low_cfg, st_reg.w_data,
                                        st_reg.w_strb);
        end
        `GPLE_IDX_LEVEL_HIGH_CFG: begin
          st_next.level_high_cfg = merge(st_reg.level_high_cfg, st_reg.w_data,
                                         st_reg.w_strb);
          st_next.level_high_cfg[15:14] = 2'h0;
        end
        `GPLE_IDX_SPARE: begin
          st_next.spare_check_word = merge(st_reg.spare_check_word, st_reg.w_data,
                                           st_reg.w_strb);
        end
        `GPLE_IDX_CHECKSUM: begin
          st_next.map_section_one_checksum = merge(st_reg.map_section_one_checksum,
                                                   st_reg.w_data, st_reg.w_strb);
        end
        default: begin
        end
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end

    // read channel
    if (s_axi_arvalid && st_reg.arready) begin
      case (ar_idx)
        `GPLE_IDX_LEVEL_LOW_CFG: rd_val = st_reg.level_low_cfg;
        `GPLE_IDX_LEVEL_HIGH_CFG: rd_val = st_reg.level_high_cfg;
        `GPLE_IDX_SPARE: rd_val = st_reg.spare_check_word;
        `GPLE_IDX_CHECKSUM: rd_val = st_reg.map_section_one_checksum;
        default: rd_val = 16'h0000;
      endcase
      st_next.rdata = {16'h0000, rd_val};
      st_next.rresp = idx_known(ar_idx) ? `GPLE_RESP_OKAY : `GPLE_RESP_SLVERR;
      st_next.rvalid = 1'b1;
      st_next.arready = 1'b0;
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end

    // time base prescaler
    if (st_reg.pre_cnt >= tb_clks(st_reg.level_low_cfg[`GPLE_TB_MSB:`GPLE_TB_LSB]) - 11'h001) begin
      tick = 1'b1;
      st_next.pre_cnt = 11'h000;
    end else begin
      st_next.pre_cnt = st_reg.pre_cnt + 11'h001;
    end

    // waveform engine
    period = {1'b0, st_reg.cur_hc} + {1'b0, st_reg.cur_lc};
    if (tick) begin
      if (st_reg.mode == gple_pkg::GPLE_PH_STATIC || st_reg.tick_cnt + 8'h01 >= period) begin
        boundary = 1'b1;
      end else begin
        st_next.tick_cnt = st_reg.tick_cnt + 8'h01;
      end
    end
    st_next.last_level = pin_level;
    if (pin_level != st_reg.last_level) begin
      boundary = 1'b1;
      st_next.pre_cnt = 11'h000;
    end
    if (boundary) begin
      // counts sampled only here, so a write to the counts never cuts a period short
      if (pin_level) begin
        hc = st_reg.level_high_cfg[`GPLE_HC_MSB:`GPLE_HC_LSB];
        lc = st_reg.level_high_cfg[`GPLE_LC_MSB:`GPLE_LC_LSB];
      end else begin
        hc = st_reg.level_low_cfg[`GPLE_HC_MSB:`GPLE_HC_LSB];
        lc = st_reg.level_low_cfg[`GPLE_LC_MSB:`GPLE_LC_LSB];
      end
      st_next.cur_hc = hc;
      st_next.cur_lc = lc;
      st_next.tick_cnt = 8'h00;
      st_next.mode = (hc == 7'h00 || lc == 7'h00) ? gple_pkg::GPLE_PH_STATIC
                                                  : gple_pkg::GPLE_PH_RUN;
    end
    if (st_next.cur_hc == 7'h00) begin
      st_next.pin_out = 1'b0;
    end else if (st_next.cur_lc == 7'h00) begin
      st_next.pin_out = 1'b1;
    end else begin
      st_next.pin_out = st_next.tick_cnt < {1'b0, st_next.cur_hc};
    end
  end

  // ==========================================================
  // state register
  // ==========================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
      st_reg.level_low_cfg <= `GPLE_RST_LEVEL_LOW_CFG;
      st_reg.level_high_cfg <= `GPLE_RST_LEVEL_HIGH_CFG;
      st_reg.spare_check_word <= `GPLE_RST_SPARE;
      st_reg.map_section_one_checksum <= `GPLE_RST_CHECKSUM;
      st_reg.mode <= gple_pkg::GPLE_PH_STATIC;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign fourth_io_overcurrent_pin = st_reg.pin_out;

endmodule

`default_nettype wire

// *** gple_encoder_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module gple_encoder_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pin
  input wire logic pin_level,
  input wire logic fourth_io_overcurrent_pin
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read upper half not zero");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  // pwm phases last at least eight clocks unless the level moves
  high_hold_a: assert property ($rose(fourth_io_overcurrent_pin)
    ##1 $stable(pin_level) [*8] |-> fourth_io_overcurrent_pin) else $error("high too short");
  low_hold_a: assert property ($fell(fourth_io_overcurrent_pin)
    ##1 $stable(pin_level) [*8] |-> !fourth_io_overcurrent_pin) else $error("low too short");
  cover property ($rose(fourth_io_overcurrent_pin));
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind gple_encoder gple_encoder_chk gple_encoder_chk_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pin_level, .fourth_io_overcurrent_pin);
`default_nettype wire

// *** gple_pin_rx.sv ***
`timescale 1ns/1ps
`default_nettype none
module gple_pin_rx (
  // clock and pin
  input wire logic aclk,
  input wire logic pin,
  // last phase lengths in clocks
  output var int hi_len,
  output var int lo_len
);
  int run = 0;
  logic last = 1'h0;
  always @(posedge aclk) begin
    if (pin === last) begin
      run++;
    end else begin
      if (last)
        hi_len <= run;
      else
        lo_len <= run;
      run = 1;
    end
    last = pin;
  end
endmodule
`default_nettype wire

// *** gple_pkg.sv ***
`default_nettype none
package gple_pkg;

  typedef enum logic {
    GPLE_PH_RUN,
    GPLE_PH_STATIC
  } gple_mode_t;

  typedef struct packed {
    // bus side
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_idx;
    logic [15:0] w_data;
    logic [1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // registers
    logic [15:0] level_low_cfg;
    logic [15:0] level_high_cfg;
    logic [15:0] spare_check_word;
    logic [15:0] map_section_one_checksum;
    // waveform engine
    logic [10:0] pre_cnt;
    logic [7:0] tick_cnt;
    logic [6:0] cur_hc;
    logic [6:0] cur_lc;
    gple_mode_t mode;
    logic last_level;
    logic pin_out;
  } gple_state_t;

endpackage
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] s_axi_awaddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [31:0] s_axi_araddr = '0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic lvl = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pin;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  int hi_len, lo_len;
  int n_mismatch = 0;
  int cmp_count = 0;
  always #20 aclk = ~aclk;
  gple_encoder gple_encoder_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pin_level(lvl), .fourth_io_overcurrent_pin(pin));
  gple_pin_rx gple_pin_rx_i (.aclk, .pin, .hi_len, .lo_len);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] i, input logic [15:0] v, input int lag = 0);
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, i, 2'h0};
    s_axi_wdata <= {16'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= (lag == 0);
    do begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end while (s_axi_awvalid || s_axi_wvalid);
    if (lag > 0) begin
      cyc(lag);
      s_axi_bready <= 1'h1;
      @(posedge aclk);
    end
    while (!s_axi_bvalid)
      @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] i, input int lag = 0);
    @(posedge aclk);
    s_axi_araddr <= {22'h0, i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= (lag == 0);
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    if (lag > 0) begin
      cyc(lag);
      s_axi_rready <= 1'h1;
    end
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  // level away and back forces a fresh period
  task automatic flip(input logic v);
    @(posedge aclk);
    lvl <= ~v;
    cyc(3);
    lvl <= v;
  endtask
  task automatic t_regs;
    rd(8'h58);
    chk("cfg_high", d, 32'h00003F80);
    rd(8'h59);
    chk("spare", d, 32'h00005555);
    rd(8'h7E);
    chk("crc", d, 32'h00000000);
    wr(8'h59, 16'hA5C3);
    rd(8'h59);
    chk("spare", d, 32'h0000A5C3);
    wr(8'h7E, 16'h1234);
    rd(8'h7E);
    chk("crc", d, 32'h00001234);
    wr(8'h58, 16'hFFFF);
    rd(8'h58);
    chk("cfg_high", d, 32'h00003FFF);
    wr(8'h3F, 16'h0001);
    chk("bresp", r, 32'h2);
    rd(8'h3F);
    chk("rdata_bad", d, 32'h0);
    chk("rresp", r, 32'h2);
    $display("t_regs done");
  endtask
  task automatic t_pwm;
    int tb;
    for (int c = 0; c < 4; c++) begin
      tb = 16 << (2 * c);
      wr(8'h57, {c[1:0], 14'h007F});
      wr(8'h58, 16'h0103);
      flip(1'h1);
      cyc(3);
      chk("first", pin, 32'h1);
      cyc(10 * tb);
      chk("high", hi_len, 2 * tb);
      chk("low", lo_len, 3 * tb);
      chk("period", hi_len + lo_len, 5 * tb);
    end
    $display("t_pwm done");
  endtask
  task automatic t_static;
    logic [15:0] cf [3] = '{16'h0005, 16'h0180, 16'h0000};
    logic [2:0] ex = 3'h2;
    wr(8'h57, 16'h007F);
    for (int k = 0; k < 3; k++) begin
      wr(8'h58, cf[k]);
      flip(1'h1);
      cyc(20);
      chk("static_a", pin, ex[k]);
      cyc(40);
      chk("static_b", pin, ex[k]);
    end
    $display("t_static done");
  endtask
  task automatic t_boundary;
    wr(8'h58, 16'h0204);
    flip(1'h1);
    wr(8'h58, 16'h0081);
    wr(8'h59, 16'h0000);
    cyc(25);
    chk("mid_phase", pin, 32'h1);
    $display("t_boundary done");
  endtask
  task automatic t_low_set;
    wr(8'h57, 16'h0082);
    flip(1'h0);
    cyc(200);
    chk("ll_high", hi_len, 32'd16);
    chk("ll_low", lo_len, 32'd32);
    $display("t_low_set done");
  endtask
  // slow ready on both answers, then a reset in mid-run
  task automatic t_slow;
    wr(8'h59, 16'h3C96, 3);
    chk("bresp_slow", r, 32'h0);
    rd(8'h59, 3);
    chk("spare_slow", d, 32'h00003C96);
    @(posedge aclk);
    aresetn <= 1'h0;
    cyc(2);
    aresetn <= 1'h1;
    rd(8'h59);
    chk("spare_rst", d, 32'h00005555);
    rd(8'h57);
    chk("cfg_low_rst", d, 32'h0000007F);
    rd(8'h7E);
    chk("crc_rst", d, 32'h00000000);
    $display("t_slow done");
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    cyc(8);
    aresetn <= 1'h1;
    t_regs;
    t_pwm;
    t_static;
    t_boundary;
    t_low_set;
    t_slow;
    wrap_up;
  end
  initial begin
    cyc(40000);
    n_mismatch++;
    wrap_up;
  end
endmodule
`default_nettype wire
